/* File: scs_map.vh */
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
// register byte addresses
`define SCS_ADDR_CTRL 12'h000
`define SCS_ADDR_STATUS 12'h004
`define SCS_ADDR_DATA 12'h008
`define SCS_ADDR_LEN 12'h00c
`define SCS_ADDR_COUNT 12'h010
// control fields
`define SCS_CTRL_INIT_EN 0
`define SCS_CTRL_PIN_VARIANT 1
`define SCS_CTRL_AUTO_RESTART 2
`define SCS_CTRL_RECONFIG 3
`define SCS_CTRL_ABORT 4
`define SCS_CTRL_RESET 8'h01
// scheme codes
`define SCS_SCHEME_SERIAL 2'h0
`define SCS_SCHEME_PAR_CLK 2'h1
`define SCS_SCHEME_PAR_MEM 2'h2
`define SCS_SCHEME_SER_UNCLK 2'h3
// stream length in bits
`define SCS_LEN_MIN 22'h01ccf0
`define SCS_LEN_MAX 22'h3b2c70
`define SCS_LEN_RESET 22'h01ccf0
// init-done high over roughly the first configuration clocks
`define SCS_INIT_CLKS 6'h28
// initialization phase length in cycles
`define SCS_INIT_PHASE 8'h20
`endif

/* File: scs_sequencer.v */
// The APB register port and the address map were decided locally.
`include "scs_map.vh"
`default_nettype none

module scs_sequencer (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // configuration pins
    input wire config_req_n,
    input wire scheme_select_lo,
    input wire scheme_select_hi,
    input wire scheme_select_pin,
    input wire fault_status_n_in,
    output reg fault_status_n_out,
    output reg fault_status_n_oe,
    output reg config_done,
    output reg init_done,
    output reg device_ready,
    // serial data stream from memory or host
    input wire cfg_clk,
    input wire cfg_data,
    // user i/o control
    output reg user_io_oe_allow,
    output reg user_io_pullup,
    output reg user_mode
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_RESET = 2'h0;
localparam ST_CONFIG = 2'h1;
localparam ST_INIT = 2'h2;
localparam ST_USER = 2'h3;

// decode of select pins; variant 1 is the single-pin part
function [1:0] scs_decode;
    input variant;
    input hi;
    input lo;
    input pin;
    begin
        if (variant)
            scs_decode = pin ? `SCS_SCHEME_SER_UNCLK : `SCS_SCHEME_SERIAL;
        else if (hi && lo)
            scs_decode = `SCS_SCHEME_PAR_MEM;
        else if (hi)
            scs_decode = `SCS_SCHEME_PAR_CLK;
        else
            scs_decode = `SCS_SCHEME_SERIAL;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// three-stage synchronisers; a change counts when stages two and three agree
reg [2:0] req_sync;
reg [2:0] clk_sync;
reg [2:0] dat_sync;
reg [2:0] flt_sync;
reg [2:0] lo_sync;
reg [2:0] hi_sync;
reg [2:0] pin_sync;
reg req_level;
reg clk_level;
reg flt_level;
reg lo_level;
reg hi_level;
reg pin_level;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        req_sync <= 3'h0;
        clk_sync <= 3'h0;
        dat_sync <= 3'h0;
        flt_sync <= 3'h7;
        lo_sync <= 3'h0;
        hi_sync <= 3'h0;
        pin_sync <= 3'h0;
        req_level <= 1'b0;
        clk_level <= 1'b0;
        flt_level <= 1'b1;
        lo_level <= 1'b0;
        hi_level <= 1'b0;
        pin_level <= 1'b0;
    end
    else
    begin
        req_sync <= {req_sync[1:0], config_req_n};
        clk_sync <= {clk_sync[1:0], cfg_clk};
        dat_sync <= {dat_sync[1:0], cfg_data};
        flt_sync <= {flt_sync[1:0], fault_status_n_in};
        lo_sync <= {lo_sync[1:0], scheme_select_lo};
        hi_sync <= {hi_sync[1:0], scheme_select_hi};
        pin_sync <= {pin_sync[1:0], scheme_select_pin};
        if (req_sync[1] == req_sync[2])
            req_level <= req_sync[2];
        if (clk_sync[1] == clk_sync[2])
            clk_level <= clk_sync[2];
        if (flt_sync[1] == flt_sync[2])
            flt_level <= flt_sync[2];
        // select pins only count once stages two and three agree, so a pin
        // that bounces near the request edge cannot pick a half-changed scheme
        if (lo_sync[1] == lo_sync[2])
            lo_level <= lo_sync[2];
        if (hi_sync[1] == hi_sync[2])
            hi_level <= hi_sync[2];
        if (pin_sync[1] == pin_sync[2])
            pin_level <= pin_sync[2];
    end
end

wire req_agree = (req_sync[1] == req_sync[2]);
wire req_rise = req_agree && req_sync[2] && !req_level;
wire req_low = req_agree && !req_sync[2];
wire clk_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_level;
wire ext_fault = (flt_sync[1] == flt_sync[2]) && !flt_sync[2] && flt_level;

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] ctrl;
reg [21:0] stream_len;
reg [21:0] bit_count;
reg [31:0] shift_word;
reg [1:0] state;
reg [1:0] scheme;
reg [5:0] init_clks;
reg [7:0] init_timer;
reg error_seen;
reg sw_reconfig;
reg sw_abort;

wire apb_access = psel && penable && pready;
wire apb_write = apb_access && pwrite;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctrl <= `SCS_CTRL_RESET;
        stream_len <= `SCS_LEN_RESET;
        sw_reconfig <= 1'b0;
        sw_abort <= 1'b0;
    end
    else
    begin
        sw_reconfig <= apb_write && paddr == `SCS_ADDR_CTRL && pwdata[`SCS_CTRL_RECONFIG];
        sw_abort <= apb_write && paddr == `SCS_ADDR_CTRL && pwdata[`SCS_CTRL_ABORT];
        if (apb_write && paddr == `SCS_ADDR_CTRL)
            ctrl <= {5'h0, pwdata[2:0]};
        // length is clamped to the legal density span
        if (apb_write && paddr == `SCS_ADDR_LEN && state == ST_RESET)
        begin
            if (pwdata[21:0] < `SCS_LEN_MIN)
                stream_len <= `SCS_LEN_MIN;
            else if (pwdata[21:0] > `SCS_LEN_MAX)
                stream_len <= `SCS_LEN_MAX;
            else
                stream_len <= pwdata[21:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer
// a request or software reconfigure beats every phase, including a fault,
// so the fault line is released as soon as the system asks again
wire restart = req_low || sw_reconfig;
wire word_bit = apb_write && paddr == `SCS_ADDR_DATA;
wire take_bit = (state == ST_CONFIG) && (clk_rise || word_bit);
// the stream length is fixed per density, so the count alone ends loading;
// a short stream never completes and must be cut by a request or abort
wire stream_full = (bit_count == stream_len);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= ST_RESET;
        scheme <= `SCS_SCHEME_SERIAL;
        bit_count <= 22'h0;
        shift_word <= 32'h0;
        init_clks <= 6'h0;
        init_timer <= 8'h0;
        error_seen <= 1'b0;
    end
    else
    begin
        if (restart)
        begin
            state <= ST_RESET;
            error_seen <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RESET:
                begin
                    // error holds until request restarts unless auto restart is set
                    if (error_seen && ctrl[`SCS_CTRL_AUTO_RESTART])
                        error_seen <= 1'b0;
                    else if (req_rise && !error_seen)
                    begin
                        scheme <= scs_decode(ctrl[`SCS_CTRL_PIN_VARIANT], hi_level,
                                             lo_level, pin_level);
                        bit_count <= 22'h0;
                        init_clks <= 6'h0;
                        state <= ST_CONFIG;
                    end
                end
                ST_CONFIG:
                begin
                    if (ext_fault || sw_abort)
                    begin
                        error_seen <= 1'b1;
                        state <= ST_RESET;
                    end
                    else if (stream_full)
                    begin
                        init_timer <= `SCS_INIT_PHASE;
                        state <= ST_INIT;
                    end
                    else if (take_bit)
                    begin
                        bit_count <= bit_count + 22'h1;
                        shift_word <= {shift_word[30:0], word_bit ? pwdata[0] : dat_sync[2]};
                        if (init_clks != `SCS_INIT_CLKS)
                            init_clks <= init_clks + 6'h1;
                    end
                end
                ST_INIT:
                begin
                    if (init_timer == 8'h0)
                        state <= ST_USER;
                    else
                        init_timer <= init_timer - 8'h1;
                end
                // user mode holds until a request; passive hosts reload from here
                ST_USER:
                    state <= ST_USER;
                default:
                    state <= ST_RESET;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin outputs, all from flip-flops
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        fault_status_n_out <= 1'b0;
        fault_status_n_oe <= 1'b1;
        config_done <= 1'b0;
        init_done <= 1'b0;
        device_ready <= 1'b0;
        user_io_oe_allow <= 1'b0;
        user_io_pullup <= 1'b0;
        user_mode <= 1'b0;
    end
    else
    begin
        fault_status_n_out <= 1'b0;
        // open drain: pull low while an error is held and while reset is asserted
        fault_status_n_oe <= error_seen;
        // done is masked by restart at once so it drops one edge after restart, four edges after the request falls
        config_done <= (state == ST_INIT || state == ST_USER) && !restart;
        // init-done counts taken bits, not pclk cycles, so a slow stream stretches it
        init_done <= ctrl[`SCS_CTRL_INIT_EN] &&
                     ((state == ST_RESET && req_agree && !req_sync[2]) ||
                      (state == ST_CONFIG && init_clks != `SCS_INIT_CLKS));
        // readiness toward the memory: in config and not faulted
        device_ready <= state == ST_CONFIG && !error_seen;
        user_io_oe_allow <= state == ST_USER && !restart;
        // pull-up is on in every non-user state, reset included, and off only in user mode or while presetn is low; it only weakens the pins,
        // it never drives them against the board
        user_io_pullup <= state != ST_USER;
        user_mode <= state == ST_USER && !restart;
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb read side; one wait state so every answer takes two cycles after setup
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        prdata <= 32'h0;
        pslverr <= 1'b0;
    end
    else
    begin
        // unmapped reads still answer, flagged by pslverr, so a host never hangs
        pready <= psel && penable && !pready;
        pslverr <= 1'b0;
        prdata <= 32'h0;
        if (psel && penable && !pready)
        begin
            case (paddr)
                `SCS_ADDR_CTRL: prdata <= {24'h0, ctrl};
                `SCS_ADDR_STATUS: prdata <= {24'h0, error_seen, scheme, user_mode,
                                             config_done, state, 1'b0};
                `SCS_ADDR_DATA: prdata <= shift_word;
                `SCS_ADDR_LEN: prdata <= {10'h0, stream_len};
                `SCS_ADDR_COUNT: prdata <= {10'h0, bit_count};
                default: pslverr <= 1'b1;
            endcase
        end
    end
end

endmodule // scs_sequencer
`default_nettype wire

/* File: scs_sva.sv */
`default_nettype none
module scs_sva (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // configuration
    input wire logic config_req_n,
    input wire logic fault_status_n_in,
    input wire logic fault_status_n_oe,
    input wire logic config_done,
    input wire logic device_ready,
    input wire logic user_mode,
    input wire logic user_io_oe_allow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // request must outlast the three-stage synchroniser
    sequence s_req_pulse;
        !config_req_n [*6] ##1 config_req_n;
    endsequence
    sequence s_one_wait;
        pready ##1 !pready;
    endsequence
    property p_pready_one;
        psel && penable && !pready |=> s_one_wait;
    endproperty
    property p_slverr;
        pslverr |-> pready;
    endproperty
    property p_done_cfg;
        device_ready |-> !config_done;
    endproperty
    property p_user_done;
        user_mode |-> config_done;
    endproperty
    property p_io_hiz;
        !user_mode |-> !user_io_oe_allow;
    endproperty
    property p_req_done;
        $fell(config_req_n) |-> ##[1:6] !config_done;
    endproperty
    property p_start;
        s_req_pulse ##0 fault_status_n_in |-> ##[1:10] device_ready;
    endproperty
    property p_fault;
        fault_status_n_oe |-> !config_done && !user_mode;
    endproperty
    a_pready_one: assert property (p_pready_one) else $error("pready timing wrong");
    a_slverr: assert property (p_slverr) else $error("pslverr without pready");
    a_done_cfg: assert property (p_done_cfg) else $error("done high while loading");
    a_user_done: assert property (p_user_done) else $error("user mode before done");
    a_io_hiz: assert property (p_io_hiz) else $error("user io driven early");
    a_req_done: assert property (p_req_done) else $error("done not cleared");
    a_start: assert property (p_start) else $error("load did not start");
    a_fault: assert property (p_fault) else $error("fault with done or user");
endmodule // scs_sva
bind scs_sequencer scs_sva i_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .config_req_n, .fault_status_n_in, .fault_status_n_oe, .config_done, .device_ready,
    .user_mode, .user_io_oe_allow);
`default_nettype wire

/* File: scs_mem_model.sv */
`default_nettype none
module scs_mem_model (
    // control
    input wire logic pclk,
    input wire logic device_ready,
    input wire logic fault_line,
    input wire logic go,
    input wire logic [7:0] half,
    // serial stream
    output var logic cfg_clk,
    output var logic cfg_data
);
    timeunit 1ns;
    timeprecision 1ps;
    integer i;
    initial
    begin
        cfg_clk = 0;
        cfg_data = 0;
        forever
        begin
            @(posedge pclk);
            // send only once both ends show ready
            if (go && device_ready && fault_line)
            begin
                for (i = 0; i < 50; i++)
                begin
                    cfg_data <= i[0] ^ i[2];
                    repeat (half) @(posedge pclk);
                    cfg_clk <= 1;
                    repeat (half) @(posedge pclk);
                    cfg_clk <= 0;
                end
                // released data line must not look like a held bit
                cfg_data <= !cfg_data;
            end
        end
    end
endmodule // scs_mem_model
`default_nettype wire

/* File: tb_top.sv */
`include "scs_map.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0;
    logic presetn, psel, penable, pwrite, config_req_n, go, pready, pslverr, fault_status_n_oe;
    logic scheme_select_lo, scheme_select_hi, scheme_select_pin, cfg_clk, cfg_data;
    logic config_done, init_done, device_ready, user_io_oe_allow, user_io_pullup, user_mode;
    logic fault_status_n_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] half;
    logic [33:0] q[$];
    logic [33:0] note;
    logic [5:0] tbl [5] = '{6'h00, 6'h11, 6'h1a, 6'h20, 6'h27};
    integer miscompares = 0, n_checks = 0, cyc = 0, k, s, seed;
    wire fault_status_n_in = !fault_status_n_oe;
    always #12.5 pclk = ~pclk;
    scs_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .config_req_n, .scheme_select_lo, .scheme_select_hi,
        .scheme_select_pin, .fault_status_n_in, .fault_status_n_out, .fault_status_n_oe,
        .config_done, .init_done, .device_ready, .cfg_clk, .cfg_data, .user_io_oe_allow,
        .user_io_pullup, .user_mode);
    scs_mem_model i_mem (.pclk, .device_ready, .fault_line(fault_status_n_in), .go, .half,
        .cfg_clk, .cfg_data);
    ////////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task chk1(input string nm, input logic seen, input logic exp);
        chk(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    // note holds {check data, expected pslverr, expected data}
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] n);
        q.push_back(n);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0, {2'b10, e});
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d, 34'h0);
    endtask
    task req(input logic [5:0] t);
        r = $random(seed);
        config_req_n <= 0;
        scheme_select_hi <= t[5] ? r[0] : t[4];
        scheme_select_lo <= t[5] ? r[1] : t[3];
        scheme_select_pin <= t[5] ? t[2] : r[2];
        repeat (8) @(posedge pclk);
        chk1("init_done", init_done, 1);
        chk1("config_done", config_done, 0);
        config_req_n <= 1;
        for (k = 0; k < 20 && device_ready !== 1'b1; k++) @(posedge pclk);
        chk1("device_ready", device_ready, 1);
    endtask
    task stream(input logic [7:0] h, input logic [31:0] n);
        half <= h;
        go <= 1;
        @(posedge pclk);
        go <= 0;
        repeat (100 * h + 20) @(posedge pclk);
        chk1("init_done", init_done, 0);
        chk1("config_done", config_done, 0);
        rd(`SCS_ADDR_COUNT, n);
    endtask
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1)
        begin
            note = q.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            if (note[33])
                chk("prdata", prdata, note[31:0]);
        end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            miscompares++;
            wrap_up;
        end
    end
    initial
    begin
        seed = 32'hfcdf;
        {presetn, psel, penable, pwrite, config_req_n, go} = 0;
        {scheme_select_lo, scheme_select_hi, scheme_select_pin} = 0;
        paddr = 0;
        pwdata = 0;
        half = 3;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        rd(`SCS_ADDR_STATUS, 32'h0);
        chk1("config_done", config_done, 0);
        chk1("user_mode", user_mode, 0);
        chk1("io_allow", user_io_oe_allow, 0);
        chk1("io_pullup", user_io_pullup, 1);
        rd(`SCS_ADDR_LEN, {10'h0, `SCS_LEN_RESET});
        wr(`SCS_ADDR_LEN, 32'h0);
        rd(`SCS_ADDR_LEN, {10'h0, `SCS_LEN_MIN});
        wr(`SCS_ADDR_LEN, 32'hffffffff);
        rd(`SCS_ADDR_LEN, {10'h0, `SCS_LEN_MAX});
        apb(0, 12'h020, 32'h0, {2'b01, 32'h0});
        for (s = 0; s < 5; s++)
        begin
            wr(`SCS_ADDR_CTRL, {30'h0, tbl[s][5], 1'b1});
            req(tbl[s]);
            r = $random(seed);
            {scheme_select_hi, scheme_select_lo, scheme_select_pin} <= r[2:0];
            rd(`SCS_ADDR_STATUS, {25'h0, tbl[s][1:0], 5'h2});
            wr(`SCS_ADDR_CTRL, 32'h11);
            repeat (3) @(posedge pclk);
            chk1("fault_oe", fault_status_n_oe, 1);
            chk1("fault_out", fault_status_n_out, 0);
            chk1("device_ready", device_ready, 0);
        end
        req(tbl[0]);
        stream(8'd3, 32'd50);
        for (s = 0; s < 4; s++) wr(`SCS_ADDR_DATA, $random(seed));
        rd(`SCS_ADDR_COUNT, 32'd54);
        req(tbl[1]);
        rd(`SCS_ADDR_COUNT, 32'd0);
        stream(8'd6, 32'd50);
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
